// ### shared/bpcr_pkg.sv
// constants and types for the banked configuration register file
package bpcr_pkg;
  localparam int BANK_COUNT = 15;
  localparam logic [7:0] LAST_BANK = 8'h0E;
  localparam logic [7:0] IDX_BANK_SEL = 8'h07;
  localparam logic [7:0] IDX_GLOBAL_LO = 8'h20;
  localparam logic [7:0] IDX_GLOBAL_HI = 8'h2F;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE0_HI = 8'h60;
  localparam logic [7:0] IDX_BASE0_LO = 8'h61;
  localparam logic [7:0] IDX_BASE1_HI = 8'h62;
  localparam logic [7:0] IDX_BASE1_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA0 = 8'h74;
  localparam logic [7:0] IDX_DMA1 = 8'h75;
  localparam logic [15:0] PORT_STRAP_LOW = 16'h002E;
  localparam logic [15:0] PORT_STRAP_HIGH = 16'h004E;
  localparam logic [15:0] DATA_PORT_OFFSET = 16'h0001;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] BANK_SEL_RESET = 8'h00;
  localparam logic [7:0] RD_MISSING = 8'h00;
  localparam logic [7:0] RD_MISSING_DMA = 8'h04;
  localparam logic [2:0] DMA_NONE = 3'h4;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [1:0] TYPE_RESET = 2'h0;
  localparam int WAKE_BIT = 4;
  localparam int POL_BIT = 1;
  localparam int TRIG_BIT = 0;
  // keyboard bank (06h) comes up active, all others off
  localparam logic [14:0] ACTIVE_RESET = 15'h0040;
  // banks whose interrupt type is fixed in hardware
  localparam logic [14:0] TYPE_READ_ONLY = 15'h0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic active;
    logic [15:0] base0;
    logic [15:0] base1;
    logic wake_en;
    logic [3:0] irq_num;
    logic [1:0] irq_type;
    logic [2:0] dma0;
    logic [2:0] dma1;
  } bpcr_bank_type;

  localparam bpcr_bank_type BANK_DETACHED = '{
    active: 1'b0, base0: 16'h0000, base1: 16'h0000, wake_en: 1'b0,
    irq_num: IRQ_NONE, irq_type: TYPE_RESET, dma0: DMA_NONE,
    dma1: DMA_NONE};
endpackage

// ### rtl/bpcr_top.sv
// banked plug-and-play configuration register file behind index/data ports
`timescale 1ns/100ps
module bpcr_top
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wr_data,
  output logic io_hit,
  output logic [7:0] io_rd_data,
  output logic io_rd_ack,
  input wire logic base_address_strap,
  output logic [3:0] glob_index,
  output logic glob_rd,
  input wire logic [7:0] glob_rd_data,
  output logic glob_wr,
  output logic [7:0] glob_wr_data,
  input wire logic [14:0] dev_irq_req,
  output logic [14:0] dev_active,
  output logic [14:0][15:0] dev_io_base0,
  output logic [14:0][15:0] dev_io_base1,
  output logic [14:0][3:0] dev_interrupt_line,
  output logic [14:0] dev_irq_high,
  output logic [14:0] dev_irq_level,
  output logic [14:0][2:0] dev_dma0,
  output logic [14:0][2:0] dev_dma1,
  output logic wake_event
);

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] bank_sel;
    bpcr_pkg::bpcr_bank_type [14:0] bank;
    bpcr_pkg::bpcr_bank_type [14:0] attached;
    logic [14:0] irq_prev;
    logic [7:0] rd_data;
    logic rd_ack;
    logic wake;
    logic glob_wr;
    logic [7:0] glob_wr_data;
  } bpcr_state_type;

  // constant reset image, built once from package values
  function automatic bpcr_state_type reset_image();
    bpcr_state_type r;
    r = '0;
    r.index = bpcr_pkg::INDEX_RESET;
    r.bank_sel = bpcr_pkg::BANK_SEL_RESET;
    r.rd_data = bpcr_pkg::RD_MISSING;
    for (int i = 0; i < bpcr_pkg::BANK_COUNT; i++)
    begin
      r.bank[i] = bpcr_pkg::BANK_DETACHED;
      r.bank[i].active = bpcr_pkg::ACTIVE_RESET[i];
      r.attached[i] = bpcr_pkg::BANK_DETACHED;
    end
    return r;
  endfunction

  localparam bpcr_state_type STATE_RESET = reset_image();

  bpcr_state_type s_q;
  bpcr_state_type s_d;
  logic [1:0] strap_sync_q;
  logic strap_q;
  logic [15:0] index_port;
  logic hit_index;
  logic hit_data;
  logic bank_ok;
  logic [3:0] bsel;
  logic is_global;
  bpcr_pkg::bpcr_bank_type cur;
  logic [7:0] rd_val;
  logic [14:0] wake_hit;

  // strap caught while reset is held, then frozen; kept out of the
  // state image, which reset loads with constants only
  // limitation: reset must span three clocks for the strap to land
  // strap sampled during reset
  always_ff @(posedge ref_clk)
  begin
    strap_sync_q <= {strap_sync_q[0], base_address_strap};
    if (sys_rst)
    begin
      strap_q <= strap_sync_q[1];
    end
  end

  // port decode, live from the first edge after reset
  // strap picks ports
  assign index_port = strap_q ? bpcr_pkg::PORT_STRAP_HIGH
                              : bpcr_pkg::PORT_STRAP_LOW;
  assign hit_index = (io_addr == index_port);
  assign hit_data = (io_addr == index_port + bpcr_pkg::DATA_PORT_OFFSET);
  assign io_hit = hit_index || hit_data;

  // bank selection; a reserved number selects nothing
  // valid bank range
  assign bank_ok = (s_q.bank_sel <= bpcr_pkg::LAST_BANK);
  assign bsel = bank_ok ? s_q.bank_sel[3:0] : 4'h0;
  assign cur = s_q.bank[bsel];
  assign is_global = (s_q.index >= bpcr_pkg::IDX_GLOBAL_LO) &&
                     (s_q.index <= bpcr_pkg::IDX_GLOBAL_HI);

  // global registers live outside; index low bits name them
  assign glob_index = s_q.index[3:0];
  assign glob_rd = io_rd && hit_data && is_global;
  assign glob_wr = s_q.glob_wr;
  assign glob_wr_data = s_q.glob_wr_data;

  // read value seen through the data port
  always_comb
  begin
    // missing registers read 00h, DMA slots 04h
    rd_val = bpcr_pkg::RD_MISSING;
    if ((s_q.index == bpcr_pkg::IDX_DMA0) ||
        (s_q.index == bpcr_pkg::IDX_DMA1))
    begin
      rd_val = bpcr_pkg::RD_MISSING_DMA;
    end
    if (s_q.index == bpcr_pkg::IDX_BANK_SEL)
    begin
      rd_val = s_q.bank_sel;
    end
    else if (is_global)
    begin
      rd_val = glob_rd_data;
    end
    else if (bank_ok)
    begin
      case (s_q.index)
        bpcr_pkg::IDX_ACTIVATE: rd_val = {7'h00, cur.active};
        bpcr_pkg::IDX_BASE0_HI: rd_val = cur.base0[15:8];
        bpcr_pkg::IDX_BASE0_LO: rd_val = cur.base0[7:0];
        bpcr_pkg::IDX_BASE1_HI: rd_val = cur.base1[15:8];
        bpcr_pkg::IDX_BASE1_LO: rd_val = cur.base1[7:0];
        bpcr_pkg::IDX_IRQ_SEL: rd_val = {3'h0, cur.wake_en, cur.irq_num};
        bpcr_pkg::IDX_IRQ_TYPE: rd_val = {6'h00, cur.irq_type};
        bpcr_pkg::IDX_DMA0: rd_val = {5'h00, cur.dma0};
        bpcr_pkg::IDX_DMA1: rd_val = {5'h00, cur.dma1};
        default: rd_val = bpcr_pkg::RD_MISSING;
      endcase
    end
  end

  // next state: host writes and reads, block outputs, wake detect
  always_comb
  begin
    s_d = s_q;
    wake_hit = 15'h0000;
    s_d.rd_ack = 1'b0;
    s_d.glob_wr = 1'b0;

    if (io_wr && hit_index)
    begin
      s_d.index = io_wr_data;
    end

    if (io_wr && hit_data)
    begin
      if (s_q.index == bpcr_pkg::IDX_BANK_SEL)
      begin
        s_d.bank_sel = io_wr_data;
      end
      else if (is_global)
      begin
        s_d.glob_wr = 1'b1;
        s_d.glob_wr_data = io_wr_data;
      end
      else if (bank_ok)
      begin
        case (s_q.index)
          bpcr_pkg::IDX_ACTIVATE: s_d.bank[bsel].active = io_wr_data[0];
          bpcr_pkg::IDX_BASE0_HI: s_d.bank[bsel].base0[15:8] = io_wr_data;
          bpcr_pkg::IDX_BASE0_LO: s_d.bank[bsel].base0[7:0] = io_wr_data;
          bpcr_pkg::IDX_BASE1_HI: s_d.bank[bsel].base1[15:8] = io_wr_data;
          bpcr_pkg::IDX_BASE1_LO: s_d.bank[bsel].base1[7:0] = io_wr_data;
          bpcr_pkg::IDX_IRQ_SEL:
          begin
            // whole byte written, wake may clear
            s_d.bank[bsel].wake_en = io_wr_data[bpcr_pkg::WAKE_BIT];
            s_d.bank[bsel].irq_num = io_wr_data[3:0];
          end
          bpcr_pkg::IDX_IRQ_TYPE:
          begin
            if (!bpcr_pkg::TYPE_READ_ONLY[bsel])
            begin
              s_d.bank[bsel].irq_type = io_wr_data[1:0];
            end
          end
          bpcr_pkg::IDX_DMA0: s_d.bank[bsel].dma0 = io_wr_data[2:0];
          bpcr_pkg::IDX_DMA1: s_d.bank[bsel].dma1 = io_wr_data[2:0];
          default: s_d.bank[bsel] = s_q.bank[bsel];
        endcase
      end
    end

    // reads answer one cycle later from a flop
    if (io_rd && (hit_index || hit_data))
    begin
      s_d.rd_ack = 1'b1;
      s_d.rd_data = hit_index ? s_q.index : rd_val;
    end

    // resources reach a block only while it is active
    for (int i = 0; i < bpcr_pkg::BANK_COUNT; i++)
    begin
      s_d.attached[i] = s_q.bank[i].active ? s_q.bank[i]
                                            : bpcr_pkg::BANK_DETACHED;
      wake_hit[i] = s_q.bank[i].active && s_q.bank[i].wake_en &&
                    (s_q.bank[i].irq_num != bpcr_pkg::IRQ_NONE) &&
                    dev_irq_req[i] && !s_q.irq_prev[i];
    end
    s_d.irq_prev = dev_irq_req;
    s_d.wake = |wake_hit;
  end

  // single state register; reset loads a constant image
  // fifteen banks held here
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign io_rd_data = s_q.rd_data;
  assign io_rd_ack = s_q.rd_ack;
  assign wake_event = s_q.wake;

  // per-block resource outputs, all straight from flops
  for (genvar g = 0; g < bpcr_pkg::BANK_COUNT; g++)
  begin : g_dev
    assign dev_active[g] = s_q.attached[g].active;
    assign dev_io_base0[g] = s_q.attached[g].base0;
    assign dev_io_base1[g] = s_q.attached[g].base1;
    assign dev_interrupt_line[g] = s_q.attached[g].irq_num;
    assign dev_irq_high[g] = s_q.attached[g].irq_type[bpcr_pkg::POL_BIT];
    assign dev_irq_level[g] = s_q.attached[g].irq_type[bpcr_pkg::TRIG_BIT];
    assign dev_dma0[g] = s_q.attached[g].dma0;
    assign dev_dma1[g] = s_q.attached[g].dma1;
  end

endmodule

// ### sim/bpcr_sva.sv
// port assertions for the banked configuration register file
`timescale 1ns/100ps
module bpcr_sva
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wr_data,
  input wire logic io_hit,
  input wire logic [7:0] io_rd_data,
  input wire logic io_rd_ack,
  input wire logic glob_rd,
  input wire logic [7:0] glob_rd_data,
  input wire logic glob_wr,
  input wire logic [7:0] glob_wr_data,
  input wire logic [14:0] dev_irq_req,
  input wire logic [14:0] dev_active,
  input wire logic [14:0][15:0] dev_io_base0,
  input wire logic [14:0][3:0] dev_interrupt_line,
  input wire logic [14:0] dev_irq_high,
  input wire logic [14:0] dev_irq_level,
  input wire logic [14:0][2:0] dev_dma0,
  input wire logic wake_event
);
  logic [14:0] req_q;
  // last request levels, so a wake can be traced to a rising edge
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      req_q <= 15'h0000;
    else
      req_q <= dev_irq_req;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rd_answer: assert property (io_rd && io_hit |=> io_rd_ack)
    else $error("read not answered");
  a_ack_cause: assert property (io_rd_ack |-> $past(io_rd && io_hit))
    else $error("read ack without read");
  a_port_decode: assert property (io_hit |-> io_addr[15:1] == 15'h0017
    || io_addr[15:1] == 15'h0027) else $error("decode outside ports");
  a_glob_wr_cause: assert property (glob_wr |->
    $past(io_wr && io_hit && io_addr[0]) && glob_wr_data == $past(io_wr_data))
    else $error("global write without data write");
  a_glob_rd_path: assert property (glob_rd |->
    io_rd && io_hit && io_addr[0] ##1 io_rd_data == $past(glob_rd_data))
    else $error("global read path broken");
  a_detached_type: assert property
    ((~dev_active & (dev_irq_high | dev_irq_level)) == 15'h0000)
    else $error("inactive block shows irq type");
  a_wake_cause: assert property (wake_event |->
    $past(|(dev_irq_req & ~req_q))) else $error("wake without request edge");
  for (genvar i = 0; i < 15; i++)
  begin : g_dev
    a_detached_res: assert property (!dev_active[i] |->
      dev_dma0[i] == 3'h4 && dev_io_base0[i] == 16'h0000
      && dev_interrupt_line[i] == 4'h0) else $error("resource not detached");
  end
endmodule
bind bpcr_top bpcr_sva u_sva (.ref_clk, .sys_rst, .io_addr, .io_wr, .io_rd,
  .io_wr_data, .io_hit, .io_rd_data, .io_rd_ack, .glob_rd, .glob_rd_data,
  .glob_wr, .glob_wr_data, .dev_irq_req, .dev_active, .dev_io_base0,
  .dev_interrupt_line, .dev_irq_high, .dev_irq_level, .dev_dma0, .wake_event);

// ### sim/bpcr_host.sv
// host model issuing byte-wide index/data port cycles
`timescale 1ns/100ps
module bpcr_host
(
  input wire logic ref_clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wr_data
);
  logic [15:0] base = 16'h002E;
  logic [7:0] exp_q[$];
  initial
  begin
    {io_addr, io_wr, io_rd, io_wr_data} = 26'h0000000;
  end
  // one strobe cycle; on release strobes drop, address and data show the inverse, never stale data
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge ref_clk);
    {io_addr, io_wr, io_rd, io_wr_data} = {a, w, !w, d};
    @(negedge ref_clk);
    {io_addr, io_wr, io_rd, io_wr_data} = {~a, 2'b00, ~d};
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    cyc(base, 1'b1, i);
    cyc(base + 16'h0001, 1'b1, d);
  endtask
  // expected byte is noted before the read is issued
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    cyc(base, 1'b1, i);
    exp_q.push_back(e);
    cyc(base + 16'h0001, 1'b0, 8'h00);
  endtask
endmodule

// ### sim/banked_pnp_config_registers_tb.sv
// self-checking bench for the banked configuration register file
`timescale 1ns/100ps
module banked_pnp_config_registers_tb;
  logic ref_clk, sys_rst, strap, io_wr, io_rd, io_hit, io_rd_ack, glob_rd;
  logic glob_wr, wake_event;
  logic [3:0] glob_index;
  logic [15:0] io_addr;
  logic [7:0] io_wr_data, io_rd_data, glob_rd_data, glob_wr_data, val[15];
  logic [14:0] dev_irq_req, dev_active, dev_irq_high, dev_irq_level;
  logic [14:0][15:0] dev_io_base0, dev_io_base1;
  logic [14:0][3:0] dev_interrupt_line;
  logic [14:0][2:0] dev_dma0, dev_dma1;
  logic [7:0] ridx[4] = '{8'h30, 8'h70, 8'h71, 8'h74};
  logic [7:0] rexp[4] = '{8'h01, 8'h1F, 8'h03, 8'h07};
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  bpcr_host host (.ref_clk, .io_addr, .io_wr, .io_rd, .io_wr_data);
  bpcr_top uut (.ref_clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wr_data,
    .io_hit, .io_rd_data, .io_rd_ack, .base_address_strap(strap),
    .glob_index, .glob_rd, .glob_rd_data, .glob_wr, .glob_wr_data,
    .dev_irq_req, .dev_active, .dev_io_base0, .dev_io_base1,
    .dev_interrupt_line, .dev_irq_high, .dev_irq_level, .dev_dma0,
    .dev_dma1, .wake_event);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // each answer takes the oldest noted value; an unnoted answer fails
  always @(negedge ref_clk)
  begin
    if (io_rd_ack === 1'b1)
      check(io_rd_data, host.exp_q.size() ? host.exp_q.pop_front() : 8'hXX);
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    {sys_rst, strap, glob_rd_data, dev_irq_req} = 25'h1000000;
    void'($urandom(32'hB77F));
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    host.rreg(8'h07, 8'h00);
    host.rreg(8'h75, 8'h04);
    host.rreg(8'h70, 8'h00);
    host.exp_q.push_back(8'h70);
    host.cyc(host.base, 1'b0, 8'h00);
    host.wreg(8'h07, 8'h06);
    host.rreg(8'h30, 8'h01);
    for (int b = 0; b < 15; b++)
    begin
      val[b] = 8'($urandom);
      host.wreg(8'h07, 8'(b));
      host.wreg(8'h60, val[b]);
      host.wreg(8'h63, ~val[b]);
    end
    for (int b = 0; b < 15; b++)
    begin
      host.wreg(8'h07, 8'(b));
      host.rreg(8'h60, val[b]);
      host.rreg(8'h63, ~val[b]);
    end
    // all ones in bank 3: reserved bits must read back 0
    host.wreg(8'h07, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      host.wreg(ridx[k], 8'hFF);
      host.rreg(ridx[k], rexp[k]);
    end
    host.wreg(8'h70, 8'h13);
    repeat (3) @(negedge ref_clk);
    check(dev_interrupt_line[3], 16'h0003);
    check({dev_irq_high[3], dev_irq_level[3]}, 16'h0003);
    check(dev_dma0[3], 16'h0007);
    check(dev_dma1[3], 16'h0004);
    check(dev_io_base0[3], {val[3], 8'h00});
    check(dev_io_base1[3], {8'h00, ~val[3]});
    dev_irq_req[3] = 1'b1;
    @(negedge ref_clk);
    check(wake_event, 16'h0001);
    dev_irq_req[3] = 1'b0;
    // plain write of the line number drops the wake enable
    host.wreg(8'h70, 8'h03);
    dev_irq_req[3] = 1'b1;
    @(negedge ref_clk);
    check(wake_event, 16'h0000);
    // firmware re-arms wake by read-modify-write before sleep
    host.rreg(8'h70, 8'h03);
    host.wreg(8'h70, 8'h13);
    dev_irq_req[3] = 1'b0;
    @(negedge ref_clk);
    dev_irq_req[3] = 1'b1;
    @(negedge ref_clk);
    check(wake_event, 16'h0001);
    host.wreg(8'h30, 8'h00);
    repeat (3) @(negedge ref_clk);
    check(dev_dma0[3], 16'h0004);
    host.wreg(8'h07, 8'h0F);
    host.wreg(8'h60, 8'hAA);
    host.rreg(8'h60, 8'h00);
    host.rreg(8'h74, 8'h04);
    host.rreg(8'h07, 8'h0F);
    host.wreg(8'h07, 8'h00);
    host.wreg(8'h40, 8'h55);
    host.rreg(8'h40, 8'h00);
    host.rreg(8'h60, val[0]);
    glob_rd_data = 8'($urandom);
    host.rreg(8'h25, glob_rd_data);
    host.wreg(8'h2A, 8'h5A);
    check({glob_wr, glob_index, glob_wr_data}, 16'h1A5A);
    // second reset with the strap moved to the upper port pair
    {sys_rst, strap} = 2'b11;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    // first access right after release, no settling wait
    host.base = 16'h004E;
    host.exp_q.push_back(8'h00);
    host.cyc(host.base, 1'b0, 8'h00);
    host.rreg(8'h30, 8'h00);
    repeat (4) @(negedge ref_clk);
    check(host.exp_q.size(), 16'h0000);
    results();
  end
endmodule
